// ===== rsld_cfg.svh
// Offsets, field positions, reset values and timing counts for the status LED driver
// Function
// R1 - Power indicator stays lit continuously once the unit has powered on.
// R2 - Wired link colour shows speed: red 10, green 100, orange 1000 Mb/s.
// R3 - Three-LED wired port indicator flashes while Ethernet data is moving.
// R4 - Three-LED operating: scanning blinks yellow, registering yellow, registered green.
// R5 - Five/six-LED operating, unregistered: first three indicators cycle left to right.
// R6 - Five/six-LED aiming: first three indicators form a bar graph of power.
// R7 - Three-LED aiming: session indicator yellow below threshold, green above it.
// R8 - Retrofit/connectorized aiming: session indicator green below threshold, yellow above.
// R9 - Dual-port unit: each port indicator lit while that port's link is present.
// R10 - Dual-port unit: each port indicator flashes for activity and speed on its port.
// R11 - Standard variants: primary link indicator lit continuously while link is present.
// R12 - Standard variants: separate activity indicator flashes during data transfer.
// R13 - Five/six-LED operating: sync indicator shows sync, session indicator shows session.
// R14 - Mode selects operating or aiming; periods in clock cycles; LED outputs registered.
`ifndef RSLD_CFG_SVH
`define RSLD_CFG_SVH

// Register byte offsets
`define RSLD_CTRL_OFF       12'h000
`define RSLD_THRESH_OFF     12'h004
`define RSLD_STATUS_OFF     12'h008

// Control fields
`define RSLD_CTRL_AIM_BIT   0
`define RSLD_CTRL_VAR_LSB   1
`define RSLD_CTRL_VAR_MSB   3

// Threshold fields, eight bits each
`define RSLD_THR_SUFF_LSB   0
`define RSLD_THR_BAR1_LSB   8
`define RSLD_THR_BAR2_LSB   16
`define RSLD_THR_BAR3_LSB   24

// Reset values
`define RSLD_CTRL_RST       32'h00000000
`define RSLD_THRESH_RST     32'hC0A08060

// Timing, in milliseconds and derived clock counts
`define RSLD_CLK_KHZ        10000
`define RSLD_BLINK_HALF_MS  250
`define RSLD_STEP_MS        300
`define RSLD_FLASH_HOLD_MS  50
`define RSLD_FLASH_PH_MS    40
`define RSLD_BLINK_CYC      (`RSLD_BLINK_HALF_MS * `RSLD_CLK_KHZ)
`define RSLD_STEP_CYC       (`RSLD_STEP_MS * `RSLD_CLK_KHZ)
`define RSLD_FLASH_HOLD_CYC (`RSLD_FLASH_HOLD_MS * `RSLD_CLK_KHZ)
`define RSLD_FLASH_PH_CYC   (`RSLD_FLASH_PH_MS * `RSLD_CLK_KHZ)

`endif

// ===== rsld_flasher.sv
// Activity flasher: holds a flash window after each activity pulse, rate set by speed
`timescale 1ns/1ps
module rsld_flasher
    import rsld_pkg::*;
#(
    parameter int unsigned HOLD  = 4,
    parameter int unsigned PHASE = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        activity,
    input  wire rsld_speed_t speed,
    output logic             flash
);

    logic [23:0] hold_q;
    logic [23:0] ph_q;
    logic [23:0] ph_len;

    // Faster links flash faster: the phase halves per speed step
    assign ph_len = 24'(PHASE) >> speed;

    // Stretch short bursts so a single frame is still visible
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 24'h000000;
        end else if (activity) begin
            hold_q <= 24'(HOLD);
        end else if (hold_q != 24'h000000) begin
            hold_q <= hold_q - 24'h000001;
        end
    end

    // Flash phase runs only inside the window, idle means steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q  <= 24'h000000;
            flash <= 1'b0;
        end else if (hold_q == 24'h000000) begin
            ph_q  <= 24'h000000;
            flash <= 1'b0;
        end else if (ph_q == 24'h000000) begin
            ph_q  <= ph_len;
            flash <= ~flash;
        end else begin
            ph_q <= ph_q - 24'h000001;
        end
    end

endmodule

// ===== rsld_led_viewer.sv
// Installer's view of the status LEDs: counts light changes and overlapping bar lights
`timescale 1ns/1ps
module rsld_led_viewer (
    input  wire logic        pclk,
    input  wire logic [7:0]  lights,
    output logic      [15:0] flips [8],
    output logic      [15:0] overlap
);
    logic [7:0] last_q;

    // Counters start clean; the bench only looks at differences
    initial begin
        last_q = 8'h00;
        overlap = 16'h0000;
        for (int i = 0; i < 8; i++) flips[i] = 16'h0000;
    end

    // An eye notices each light turning on or off, and two bar lights at once
    always @(posedge pclk) begin
        last_q <= lights;
        for (int i = 0; i < 8; i++) begin
            if (lights[i] !== last_q[i]) flips[i] <= flips[i] + 16'h0001;
        end
        if ($countones(lights[5:3]) > 1) overlap <= overlap + 16'h0001;
    end
endmodule

// ===== rsld_pkg.sv
// Types shared by the status LED driver files
package rsld_pkg;

    typedef enum logic [1:0] {RSLD_SPD_10, RSLD_SPD_100, RSLD_SPD_1000} rsld_speed_t;

    typedef enum logic [1:0] {RSLD_SES_SCAN, RSLD_SES_REGISTERING, RSLD_SES_REGISTERED} rsld_session_t;

    typedef enum logic [2:0] {RSLD_VAR_THREE, RSLD_VAR_RETRO, RSLD_VAR_MULTI, RSLD_VAR_DUAL} rsld_variant_t;

    typedef enum logic [2:0] {RSLD_RED, RSLD_GREEN, RSLD_ORANGE, RSLD_YELLOW} rsld_colour_t;

    typedef struct packed {
        logic         on;
        rsld_colour_t colour;
    } rsld_led_t;

    typedef struct packed {
        logic        up;
        rsld_speed_t speed;
        logic        activity;
    } rsld_port_t;

endpackage

// ===== rsld_ticker.sv
// Free-running half-period ticker: one-cycle tick and a toggling level
`timescale 1ns/1ps
module rsld_ticker #(
    parameter int unsigned HALF = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick,
    output logic      level
);

    logic [23:0] cnt_q;

    // Wrap at the half period, toggling the level each time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 24'h000000;
            tick  <= 1'b0;
            level <= 1'b0;
        end else if (cnt_q == 24'(HALF - 1)) begin
            cnt_q <= 24'h000000;
            tick  <= 1'b1;
            level <= ~level;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
            tick  <= 1'b0;
        end
    end

endmodule

// ===== rsld_top.sv
// Status LED driver top: APB registers, indication logic and LED output registers
`timescale 1ns/1ps
`include "rsld_cfg.svh"
module rsld_top
    import rsld_pkg::*;
#(
    parameter int unsigned BLINK_HALF = `RSLD_BLINK_CYC,
    parameter int unsigned STEP_CYC   = `RSLD_STEP_CYC,
    parameter int unsigned FLASH_HOLD = `RSLD_FLASH_HOLD_CYC,
    parameter int unsigned FLASH_PH   = `RSLD_FLASH_PH_CYC
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          power_good,
    input  wire rsld_port_t    port_main,
    input  wire rsld_port_t    port_aux,
    input  wire rsld_session_t session_state,
    input  wire logic          in_sync,
    input  wire logic          in_session,
    input  wire logic [7:0]    rx_level,
    output logic               power_indicator,
    output rsld_led_t          wired_port_indicator,
    output rsld_led_t          combined_session_indicator,
    output logic               bar_position_one,
    output logic               bar_position_two,
    output logic               bar_position_three,
    output rsld_led_t          primary_link_indicator,
    output logic               activity_indicator,
    output logic               primary_port_link_activity,
    output logic               secondary_port_link_activity
);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Link speed to indicator colour
    function automatic rsld_colour_t speed_colour(input rsld_speed_t s);
        case (s)
            RSLD_SPD_10:  speed_colour = RSLD_RED;
            RSLD_SPD_100: speed_colour = RSLD_GREEN;
            default:      speed_colour = RSLD_ORANGE;
        endcase
    endfunction

    // Received level strictly above a threshold field
    function automatic logic above(input logic [7:0] lvl, input logic [7:0] thr);
        above = lvl > thr;
    endfunction

    logic          aim_q;
    rsld_variant_t variant_q;
    logic [31:0]   thr_q;
    logic [1:0]    step_q;
    logic          access;
    logic          unmapped;
    logic [31:0]   status;
    logic [7:0]    thr_suff;
    logic [7:0]    thr_bar1;
    logic [7:0]    thr_bar2;
    logic [7:0]    thr_bar3;
    logic          blink_lvl;
    logic          step_tick;
    logic          flash_main;
    logic          flash_aux;
    rsld_led_t     wired_d;
    rsld_led_t     sess_d;
    rsld_led_t     prim_d;
    logic [2:0]    bars_d;
    logic          act_d;
    logic          pact_d;
    logic          aact_d;

    assign thr_suff = thr_q[`RSLD_THR_SUFF_LSB +: 8];
    assign thr_bar1 = thr_q[`RSLD_THR_BAR1_LSB +: 8];
    assign thr_bar2 = thr_q[`RSLD_THR_BAR2_LSB +: 8];
    assign thr_bar3 = thr_q[`RSLD_THR_BAR3_LSB +: 8];

    // Scanning blink and sequence step timebases
    rsld_ticker #(.HALF(BLINK_HALF)) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (),
        .level   (blink_lvl)
    );

    rsld_ticker #(.HALF(STEP_CYC)) u_step (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (step_tick),
        .level   ()
    );

    // One flasher per wired port
    rsld_flasher #(.HOLD(FLASH_HOLD), .PHASE(FLASH_PH)) u_flash_main (
        .pclk     (pclk),
        .presetn  (presetn),
        .activity (port_main.activity),
        .speed    (port_main.speed),
        .flash    (flash_main)
    );

    rsld_flasher #(.HOLD(FLASH_HOLD), .PHASE(FLASH_PH)) u_flash_aux (
        .pclk     (pclk),
        .presetn  (presetn),
        .activity (port_aux.activity),
        .speed    (port_aux.speed),
        .flash    (flash_aux)
    );

    // APB decode: answer in the second access cycle so every output is a flop
    assign access   = psel & penable;
    assign unmapped = (paddr != `RSLD_CTRL_OFF) && (paddr != `RSLD_THRESH_OFF) && (paddr != `RSLD_STATUS_OFF);
    assign status   = 32'({secondary_port_link_activity, primary_port_link_activity, activity_indicator,
                           primary_link_indicator, bar_position_three, bar_position_two, bar_position_one,
                           combined_session_indicator, wired_port_indicator, power_indicator});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & unmapped;
            if (access & ~pready & ~pwrite) begin
                case (paddr)
                    `RSLD_CTRL_OFF:   prdata <= 32'({variant_q, aim_q});
                    `RSLD_THRESH_OFF: prdata <= thr_q;
                    `RSLD_STATUS_OFF: prdata <= status;
                    default:          prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Writes land only at the edge where the master sees pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aim_q     <= 1'(`RSLD_CTRL_RST >> `RSLD_CTRL_AIM_BIT);
            variant_q <= rsld_variant_t'(3'(`RSLD_CTRL_RST >> `RSLD_CTRL_VAR_LSB));
            thr_q     <= `RSLD_THRESH_RST;
        end else if (access & pready & pwrite) begin
            if (paddr == `RSLD_CTRL_OFF) begin
                aim_q     <= pwdata[`RSLD_CTRL_AIM_BIT]; // R14
                variant_q <= rsld_variant_t'(pwdata[`RSLD_CTRL_VAR_MSB:`RSLD_CTRL_VAR_LSB]);
            end
            if (paddr == `RSLD_THRESH_OFF) begin
                thr_q <= pwdata;
            end
        end
    end

    // Left-to-right scan position, four steps with an all-dark gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 2'h0;
        end else if (step_tick) begin
            step_q <= step_q + 2'h1;
        end
    end

    // Indication decode per hardware variant
    always_comb begin
        wired_d = '{on: 1'b0, colour: speed_colour(port_main.speed)}; // R2
        sess_d  = '{on: 1'b1, colour: RSLD_YELLOW};
        prim_d  = '{on: 1'b0, colour: speed_colour(port_main.speed)};
        bars_d  = 3'h0;
        act_d   = 1'b0;
        pact_d  = 1'b0;
        aact_d  = 1'b0;
        case (variant_q)
            RSLD_VAR_THREE, RSLD_VAR_RETRO: begin
                // Dark half of each flash marks traffic on the wired port
                wired_d.on = port_main.up & ~flash_main; // R3
                if (aim_q) begin
                    if (variant_q == RSLD_VAR_THREE) begin
                        sess_d.colour = above(rx_level, thr_suff) ? RSLD_GREEN : RSLD_YELLOW; // R7
                    end else begin
                        sess_d.colour = above(rx_level, thr_suff) ? RSLD_YELLOW : RSLD_GREEN; // R8
                    end
                end else begin
                    // The retrofit units swap the two session colours
                    case (session_state)
                        RSLD_SES_SCAN: begin
                            sess_d.on     = blink_lvl; // R4
                            sess_d.colour = (variant_q == RSLD_VAR_THREE) ? RSLD_YELLOW : RSLD_GREEN;
                        end
                        RSLD_SES_REGISTERING: begin
                            sess_d.colour = (variant_q == RSLD_VAR_THREE) ? RSLD_YELLOW : RSLD_GREEN; // R4
                        end
                        default: begin
                            sess_d.colour = (variant_q == RSLD_VAR_THREE) ? RSLD_GREEN : RSLD_YELLOW; // R4
                        end
                    endcase
                end
            end
            RSLD_VAR_MULTI: begin
                sess_d.on = 1'b0;
                prim_d.on = port_main.up; // R11
                act_d     = flash_main; // R12
                if (aim_q) begin
                    // Higher bars need the lower ones, so the graph never has holes
                    bars_d[0] = above(rx_level, thr_bar1); // R6
                    bars_d[1] = bars_d[0] & above(rx_level, thr_bar2); // R6
                    bars_d[2] = bars_d[1] & above(rx_level, thr_bar3); // R6
                end else if (session_state != RSLD_SES_REGISTERED) begin
                    bars_d = (step_q == 2'h3) ? 3'h0 : 3'(3'h1 << step_q); // R5
                end else begin
                    bars_d = {1'b0, in_session, in_sync}; // R13
                end
            end
            RSLD_VAR_DUAL: begin
                sess_d.on = 1'b0;
                pact_d    = port_main.up & ~flash_main; // R9
                aact_d    = port_aux.up & ~flash_aux; // R10
            end
            default: begin
                sess_d.on = 1'b0;
            end
        endcase
    end

    // Power indicator latches on at first power-good
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_indicator <= 1'b0;
        end else begin
            power_indicator <= power_indicator | power_good; // R1
        end
    end

    // All LED drives leave the block from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wired_port_indicator         <= '{on: 1'b0, colour: RSLD_RED};
            combined_session_indicator   <= '{on: 1'b0, colour: RSLD_RED};
            primary_link_indicator       <= '{on: 1'b0, colour: RSLD_RED};
            bar_position_one             <= 1'b0;
            bar_position_two             <= 1'b0;
            bar_position_three           <= 1'b0;
            activity_indicator           <= 1'b0;
            primary_port_link_activity   <= 1'b0;
            secondary_port_link_activity <= 1'b0;
        end else begin
            wired_port_indicator         <= wired_d;
            combined_session_indicator   <= sess_d;
            primary_link_indicator       <= prim_d;
            bar_position_one             <= bars_d[0];
            bar_position_two             <= bars_d[1];
            bar_position_three           <= bars_d[2];
            activity_indicator           <= act_d;
            primary_port_link_activity   <= pact_d;
            secondary_port_link_activity <= aact_d; // R14
        end
    end

    power_stays_lit_a: assert property ((power_good || power_indicator) |=> power_indicator) // R1
        else $error("power indicator not held lit");

    speed_colour_a: assert property ((variant_q == RSLD_VAR_THREE && port_main.up) // R2
        |=> wired_port_indicator.colour == speed_colour($past(port_main.speed)))
        else $error("wired indicator colour does not match speed");

    wired_flash_a: assert property ((variant_q == RSLD_VAR_THREE && port_main.up) // R3
        |=> wired_port_indicator.on == !$past(flash_main))
        else $error("wired indicator does not follow flash");

    scan_blink_a: assert property ((variant_q == RSLD_VAR_THREE && !aim_q && session_state == RSLD_SES_SCAN) // R4
        |=> combined_session_indicator.on == $past(blink_lvl) && combined_session_indicator.colour == RSLD_YELLOW)
        else $error("scanning session indicator not blinking yellow");

    registered_green_a: assert property ((variant_q == RSLD_VAR_THREE && !aim_q // R4
        && session_state == RSLD_SES_REGISTERED) ##1 (variant_q == RSLD_VAR_THREE && !aim_q
        && session_state == RSLD_SES_REGISTERED) |=> combined_session_indicator.on
        && combined_session_indicator.colour == RSLD_GREEN)
        else $error("registered session indicator not solid green");

    bar_cycle_a: assert property ((variant_q == RSLD_VAR_MULTI && !aim_q && session_state != RSLD_SES_REGISTERED // R5
        && step_q == 2'h0) |=> bar_position_one && !bar_position_two && !bar_position_three)
        else $error("scan sequence does not start at the left indicator");

    bar_graph_a: assert property ((variant_q == RSLD_VAR_MULTI && aim_q) // R6
        |=> bar_position_one == $past(rx_level > thr_bar1)
        && (!bar_position_three || bar_position_two) && (!bar_position_two || bar_position_one))
        else $error("bar graph does not follow received level");

    aim_three_a: assert property ((variant_q == RSLD_VAR_THREE && aim_q && rx_level > thr_suff) // R7
        |=> combined_session_indicator.colour == RSLD_GREEN)
        else $error("three-LED aiming colour wrong above threshold");

    aim_retro_a: assert property ((variant_q == RSLD_VAR_RETRO && aim_q && rx_level <= thr_suff) // R8
        |=> combined_session_indicator.colour == RSLD_GREEN)
        else $error("retrofit aiming colour wrong below threshold");

    dual_link_a: assert property ((variant_q == RSLD_VAR_DUAL && !port_aux.up) // R9
        |=> !secondary_port_link_activity)
        else $error("aux indicator lit without link");

    dual_flash_a: assert property ((variant_q == RSLD_VAR_DUAL && port_main.up) // R10
        |=> primary_port_link_activity == !$past(flash_main))
        else $error("main port indicator does not flash with activity");

    primary_link_a: assert property ((variant_q == RSLD_VAR_MULTI) // R11
        |=> primary_link_indicator.on == $past(port_main.up))
        else $error("primary link indicator does not follow link");

    activity_led_a: assert property ((variant_q == RSLD_VAR_MULTI) // R12
        |=> activity_indicator == $past(flash_main))
        else $error("activity indicator does not follow flash");

    sync_session_a: assert property ((variant_q == RSLD_VAR_MULTI && !aim_q // R13
        && session_state == RSLD_SES_REGISTERED)
        |=> bar_position_one == $past(in_sync) && bar_position_two == $past(in_session))
        else $error("sync or session indicator wrong");

    mode_write_a: assert property ((access && pready && pwrite && paddr == `RSLD_CTRL_OFF) // R14
        |=> aim_q == $past(pwdata[`RSLD_CTRL_AIM_BIT]))
        else $error("mode bit not taken from write");

endmodule

// ===== tb_radio_status_led_driver.sv
// Self-checking bench for the status LED driver: APB set-up and LED observation
`timescale 1ns/1ps
`include "rsld_cfg.svh"
module tb_radio_status_led_driver;
    import rsld_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdata;
    logic          power_good, in_sync, in_session, power_indicator, rerr;
    rsld_port_t    port_main, port_aux;
    rsld_session_t session_state;
    logic [7:0]    rx_level;
    rsld_led_t     wired_port_indicator, combined_session_indicator, primary_link_indicator;
    logic          bar_position_one, bar_position_two, bar_position_three;
    logic          activity_indicator, primary_port_link_activity, secondary_port_link_activity;
    logic [15:0]   flips [8];
    logic [15:0]   overlap, ov0;
    int            failures, num_checks, cyc;
    rsld_colour_t  spd_col [3] = '{RSLD_RED, RSLD_GREEN, RSLD_ORANGE};
    logic [7:0]    bar_rx [5] = '{8'h80, 8'h81, 8'hA1, 8'hC0, 8'hC1};
    logic [2:0]    bar_exp [5] = '{3'h0, 3'h4, 3'h6, 3'h6, 3'h7};

    rsld_top #(.BLINK_HALF(8), .STEP_CYC(8), .FLASH_HOLD(20), .FLASH_PH(4)) u_rsld_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_good(power_good),
        .port_main(port_main), .port_aux(port_aux), .session_state(session_state), .in_sync(in_sync),
        .in_session(in_session), .rx_level(rx_level), .power_indicator(power_indicator),
        .wired_port_indicator(wired_port_indicator), .combined_session_indicator(combined_session_indicator),
        .bar_position_one(bar_position_one), .bar_position_two(bar_position_two),
        .bar_position_three(bar_position_three), .primary_link_indicator(primary_link_indicator),
        .activity_indicator(activity_indicator), .primary_port_link_activity(primary_port_link_activity),
        .secondary_port_link_activity(secondary_port_link_activity));
    rsld_led_viewer u_rsld_led_viewer (.pclk(pclk), .flips(flips), .overlap(overlap),
        .lights({primary_port_link_activity, activity_indicator, bar_position_three, bar_position_two,
                 bar_position_one, combined_session_indicator.on, wired_port_indicator.on, power_indicator}));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic cfg(input logic aim, input rsld_variant_t v);
        apb(1'b1, `RSLD_CTRL_OFF, {28'h0000000, v, aim});
    endtask

    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // One-cycle activity pulse on the main port
    task automatic pulse();
        @(posedge pclk);
        port_main.activity <= 1'b1;
        @(posedge pclk);
        port_main.activity <= 1'b0;
    endtask

    // Checks whether a light changed within a number of cycles
    task automatic watch(input int idx, input int n, input logic exp);
        logic [15:0] b;
        b = flips[idx];
        repeat (n) @(posedge pclk);
        chk("light change", {31'h0, flips[idx] != b}, {31'h0, exp});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, power_good, in_sync, in_session, rx_level} = '0;
        port_main = '0;
        port_aux = '0;
        session_state = RSLD_SES_REGISTERING;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `RSLD_CTRL_OFF, 32'h0);
        chk("ctrl reset", rdata, `RSLD_CTRL_RST);
        apb(1'b0, `RSLD_THRESH_OFF, 32'h0);
        chk("thresh reset", rdata, `RSLD_THRESH_RST);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        $display("test registers done");
        power_good <= 1'b1;
        settle();
        chk("power", {31'h0, power_indicator}, 32'h1);
        for (int s = 0; s < 3; s++) begin
            port_main <= '{1'b1, rsld_speed_t'(s), 1'b0};
            settle();
            chk("wired colour", {28'h0, wired_port_indicator}, {28'h0, 1'b1, spd_col[s]});
        end
        pulse();
        watch(1, 25, 1'b1);
        watch(1, 20, 1'b0);
        $display("test wired port done");
        settle();
        chk("session", {28'h0, combined_session_indicator}, {28'h0, 1'b1, RSLD_YELLOW});
        session_state <= RSLD_SES_REGISTERED;
        settle();
        chk("session", {28'h0, combined_session_indicator}, {28'h0, 1'b1, RSLD_GREEN});
        session_state <= RSLD_SES_SCAN;
        watch(2, 20, 1'b1);
        chk("scan colour", {29'h0, combined_session_indicator.colour}, {29'h0, RSLD_YELLOW});
        $display("test session done");
        for (int v = 0; v < 2; v++) begin
            cfg(1'b1, rsld_variant_t'(v));
            rx_level <= 8'h60;
            settle();
            chk("aim low", {29'h0, combined_session_indicator.colour},
                {29'h0, (v == 0) ? RSLD_YELLOW : RSLD_GREEN});
            rx_level <= 8'h61;
            settle();
            chk("aim high", {29'h0, combined_session_indicator.colour},
                {29'h0, (v == 0) ? RSLD_GREEN : RSLD_YELLOW});
        end
        cfg(1'b1, RSLD_VAR_MULTI);
        for (int i = 0; i < 5; i++) begin
            rx_level <= bar_rx[i];
            settle();
            chk("bar graph", {29'h0, bar_position_one, bar_position_two, bar_position_three},
                {29'h0, bar_exp[i]});
        end
        $display("test aiming done");
        cfg(1'b0, RSLD_VAR_MULTI);
        settle(); // The full bar graph stays lit for one more edge
        ov0 = overlap;
        for (int i = 3; i < 6; i++) watch(i, 40, 1'b1);
        chk("scan overlap", {16'h0, overlap}, {16'h0, ov0});
        session_state <= RSLD_SES_REGISTERED;
        in_sync <= 1'b1;
        settle();
        chk("sync", {29'h0, bar_position_one, bar_position_two, bar_position_three}, 32'h4);
        in_sync <= 1'b0;
        in_session <= 1'b1;
        settle();
        chk("in session", {29'h0, bar_position_one, bar_position_two, bar_position_three}, 32'h2);
        chk("primary link", {28'h0, primary_link_indicator}, {28'h0, 1'b1, RSLD_ORANGE});
        pulse();
        watch(6, 25, 1'b1);
        port_main <= '0;
        settle();
        chk("primary off", {31'h0, primary_link_indicator.on}, 32'h0);
        $display("test standard variant done");
        cfg(1'b0, RSLD_VAR_DUAL);
        port_aux <= '{1'b1, RSLD_SPD_100, 1'b0};
        settle();
        chk("dual links", {30'h0, primary_port_link_activity, secondary_port_link_activity}, 32'h1);
        port_main <= '{1'b1, RSLD_SPD_1000, 1'b0};
        settle();
        chk("dual links", {30'h0, primary_port_link_activity, secondary_port_link_activity}, 32'h3);
        pulse();
        watch(7, 25, 1'b1);
        $display("test dual port done");
        conclude();
    end
endmodule
